// ### verilog/dhis_map.svh
// constants of the display host interface select block.
// assumes inclusion by the package and the modules of this block only.
// Operation
// - low select bits come from strap pins
// - upper select bits set by width command
// - straps 00 four-wire serial, 01 three-wire
// - straps 11 6800, 10 8080; upper gives width
// - transfers accepted only while chip selected
// - reset pin low clears bus state and upper bits
// - data/command high means data, low command
// - 6800 direction high reads, low writes
// - 8080 write begins on write strobe fall
// - 6800 cycle begins on enable rise
// - 8080 read begins on read strobe fall
// - oscillator select high uses internal oscillator
// - oscillator select low uses external clock pin
// - data bus two-way, device drives on reads
// - 6800 write latched on enable fall
// - 8080 write captured on write strobe rise
// - four-wire serial shifts eight bits, msb first
// - three-wire serial shifts flag plus eight bits
`ifndef DHIS_MAP_SVH
`define DHIS_MAP_SVH

`define DHIS_SEL_SPI4     2'h0
`define DHIS_SEL_SPI3     2'h1
`define DHIS_SEL_6800     2'h3
`define DHIS_SEL_8080     2'h2
`define DHIS_UPPER_W8     2'h0
`define DHIS_UPPER_W16    2'h1
`define DHIS_UPPER_W18    2'h3
`define DHIS_UPPER_RST    2'h0
`define DHIS_WIDTH_CMD    8'hAB
`define DHIS_WIDTH_HI     7
`define DHIS_WIDTH_LO     6
`define DHIS_SPI4_BITS    4'h8
`define DHIS_SPI3_BITS    4'h9
`define DHIS_MASK_W8      18'h000FF
`define DHIS_MASK_W16     18'h0FFFF
`define DHIS_MASK_W18     18'h3FFFF
`define DHIS_OSC_DIV      8
`define DHIS_PIN_IDLE     27'h4000000

`endif

// ### verilog/dhis_pkg.sv
// types of the display host interface select block.
// assumes dhis_map.svh is on the include path.
package dhis_pkg;

   // synchronised pin bundle; cs_n sits in the top bit
   typedef struct packed {
      logic        cs_n;
      logic        dc;
      logic        rw_wr_n;
      logic        e_rd_n;
      logic        ext_clk;
      logic        rst_n;
      logic [1:0]  strap;
      logic        osc_sel;
      logic [17:0] d;
   } dhis_pins_t;

   // one word handed to the core side
   typedef struct packed {
      logic        is_data;
      logic [17:0] value;
   } dhis_word_t;

   typedef enum logic [3:0] {
      DHIS_SPI4  = 4'h1,
      DHIS_SPI3  = 4'h2,
      DHIS_M6800 = 4'h4,
      DHIS_M8080 = 4'h8
   } dhis_mode_t;

endpackage

// ### verilog/dhis_sync.sv
// two-flop synchroniser, one chain per bit.
// assumes RST_VAL is the idle level of each pin.
`timescale 1ns/1ps
module dhis_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // pins
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] d_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_ff;
         logic sync_ff;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_ff <= RST_VAL[i];
               sync_ff <= RST_VAL[i];
            end else begin
               meta_ff <= d_in[i];
               sync_ff <= meta_ff;
            end
         end
         assign d_out[i] = sync_ff;
      end
   endgenerate
endmodule

// ### verilog/dhis_buf.sv
// two-entry word buffer with valid/ready on both sides.
// assumes one clock; in_ready low means both entries hold words.
`timescale 1ns/1ps
module dhis_buf #(
   parameter int W = 19
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   logic [W-1:0] mem_ff [2];
   logic [W-1:0] nxt_mem [2];
   logic         wp_ff, nxt_wp;
   logic         rp_ff, nxt_rp;
   logic [1:0]   cnt_ff, nxt_cnt;
   logic         push, pop;

   assign in_ready  = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data  = mem_ff[rp_ff];

   always_comb begin
      push    = in_valid && in_ready;
      pop     = out_valid && out_ready;
      nxt_wp  = wp_ff ^ push;
      nxt_rp  = rp_ff ^ pop;
      nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
      nxt_mem = mem_ff;
      if (push) begin
         nxt_mem[wp_ff] = in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_ff[0] <= '0;
         mem_ff[1] <= '0;
         wp_ff     <= 1'b0;
         rp_ff     <= 1'b0;
         cnt_ff    <= 2'h0;
      end else begin
         mem_ff <= nxt_mem;
         wp_ff  <= nxt_wp;
         rp_ff  <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

// ### verilog/dhis_top.sv
// host interface front end: mode select, parallel and serial capture,
// read drive, clock source select.
// assumes all pins are asynchronous to clk; core side is on clk.
// assumes the core answers read_word in the cycle of read_req.
`timescale 1ns/1ps
`include "dhis_map.svh"
module dhis_top
   import dhis_pkg::*;
#(
   parameter int OSC_DIV = `DHIS_OSC_DIV
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // straps, external clock and reset pin
   input  wire logic [1:0]  interface_strap_bits,
   input  wire logic        oscillator_select,
   input  wire logic        external_clock_in,
   input  wire logic        chip_reset_n,
   // host control pins
   input  wire logic        cs_n,
   input  wire logic        dc_sel,
   input  wire logic        rw_wr_n,
   input  wire logic        e_rd_n,
   // host data bus, split three ways
   input  wire logic [17:0] data_in,
   output logic      [17:0] data_out,
   output logic             data_oe,
   // written words to the core
   output logic             word_valid,
   input  wire logic        word_ready,
   output dhis_word_t       word,
   output logic             bus_busy,
   // reads from the core
   output logic             read_req,
   output logic             read_is_data,
   input  wire logic [17:0] read_word,
   // status
   output logic [3:0]       interface_select_code,
   output dhis_mode_t       active_mode,
   output logic             chip_in_reset,
   output logic             display_clk_tick
);

   dhis_pins_t pin_raw, pin_s, pin_q_ff, nxt_pin_q;

   assign pin_raw.cs_n    = cs_n;
   assign pin_raw.dc      = dc_sel;
   assign pin_raw.rw_wr_n = rw_wr_n;
   assign pin_raw.e_rd_n  = e_rd_n;
   assign pin_raw.ext_clk = external_clock_in;
   assign pin_raw.rst_n   = chip_reset_n;
   assign pin_raw.strap   = interface_strap_bits;
   assign pin_raw.osc_sel = oscillator_select;
   assign pin_raw.d       = data_in;

   // every pin, the straps too, is retimed before any logic sees it
   // the cost is two clocks of latency on every strobe, so the host must
   // hold each pin level for three clocks or more
   dhis_sync #(
      .W       ($bits(dhis_pins_t)),
      .RST_VAL (`DHIS_PIN_IDLE)
   ) u_sync (
      .clk   (clk),
      .rst   (rst),
      .d_in  (pin_raw),
      .d_out (pin_s)
   );

   // bus state
   logic [1:0]  upper_ff, nxt_upper;
   logic        armed_ff, nxt_armed;
   logic        act_ff, nxt_act;
   logic        oe_ff, nxt_oe;
   logic [17:0] dout_ff, nxt_dout;
   logic [8:0]  shift_ff, nxt_shift;
   logic [3:0]  cnt_ff, nxt_cnt;
   // clock source state
   logic [7:0]  osc_ff, nxt_osc;
   logic        tick_ff, nxt_tick;

   logic        wr_fire, rd_start, buf_in_ready;
   dhis_word_t  wr_word;
   dhis_mode_t  mode;
   logic [17:0] width_mask;
   logic        e_rise, e_fall, wr_rise, wr_fall, rd_rise, rd_fall;
   logic        sck_rise, sck_now, sck_old, serial_data_in;
   logic [3:0]  ser_bits;
   logic [8:0]  shifted;

   // a strap that moves while selected switches mode mid-transfer; the
   // board wiring is trusted not to do that

   // low bits are the straps, upper bits the programmed pair
   assign interface_select_code = {upper_ff, pin_s.strap};

   always_comb begin
      unique case (pin_s.strap)
         `DHIS_SEL_SPI4: mode = DHIS_SPI4;
         `DHIS_SEL_SPI3: mode = DHIS_SPI3;
         `DHIS_SEL_6800: mode = DHIS_M6800;
         `DHIS_SEL_8080: mode = DHIS_M8080;
      endcase
   end

   // code 10 in the upper pair is not a defined width; it acts as 8 bits
   always_comb begin
      unique case (upper_ff)
         `DHIS_UPPER_W16: width_mask = `DHIS_MASK_W16;
         `DHIS_UPPER_W18: width_mask = `DHIS_MASK_W18;
         default:         width_mask = `DHIS_MASK_W8;
      endcase
   end

   // strobe edges, all from the retimed copies
   assign e_rise  =  pin_s.e_rd_n  && !pin_q_ff.e_rd_n;
   assign e_fall  = !pin_s.e_rd_n  &&  pin_q_ff.e_rd_n;
   assign rd_rise = e_rise;
   assign rd_fall = e_fall;
   assign wr_rise =  pin_s.rw_wr_n && !pin_q_ff.rw_wr_n;
   assign wr_fall = !pin_s.rw_wr_n &&  pin_q_ff.rw_wr_n;

   // four-wire clocks on the write strobe pin, three-wire on d0
   assign sck_now  = (mode == DHIS_SPI4) ? pin_s.rw_wr_n : pin_s.d[0];
   assign sck_old  = (mode == DHIS_SPI4) ? pin_q_ff.rw_wr_n
                                         : pin_q_ff.d[0];
   assign serial_data_in     = (mode == DHIS_SPI4) ? pin_s.d[0] : pin_s.d[1];
   assign sck_rise = sck_now && !sck_old;
   assign ser_bits = (mode == DHIS_SPI4) ? `DHIS_SPI4_BITS
                                         : `DHIS_SPI3_BITS;
   assign shifted  = {shift_ff[7:0], serial_data_in};

   always_comb begin
      nxt_pin_q = pin_s;
      nxt_upper = upper_ff;
      nxt_armed = armed_ff;
      nxt_act   = act_ff;
      nxt_oe    = oe_ff;
      nxt_dout  = dout_ff;
      nxt_shift = shift_ff;
      nxt_cnt   = cnt_ff;
      wr_fire   = 1'b0;
      rd_start  = 1'b0;
      wr_word   = '0;
      if (!pin_s.rst_n) begin
         nxt_upper = `DHIS_UPPER_RST;
         nxt_armed = 1'b0;
         nxt_act   = 1'b0;
         nxt_oe    = 1'b0;
         nxt_cnt   = 4'h0;
      end else if (pin_s.cs_n) begin
         // a half-done cycle or partial serial byte is dropped
         nxt_act = 1'b0;
         nxt_oe  = 1'b0;
         nxt_cnt = 4'h0;
      end else begin
         // no dummy-read pipeline: the core answers in the cycle that
         // read_req pulses, so the first read is already valid
         unique case (mode)
            DHIS_M6800: begin
               if (e_rise) begin
                  nxt_act = 1'b1;
                  if (pin_s.rw_wr_n) begin
                     rd_start = 1'b1;
                     nxt_oe   = 1'b1;
                     nxt_dout = read_word;
                  end
               end
               if (e_fall && act_ff) begin
                  nxt_act = 1'b0;
                  nxt_oe  = 1'b0;
                  wr_fire = !pin_s.rw_wr_n;
               end
               wr_word.is_data = pin_s.dc;
               wr_word.value   = pin_s.d & width_mask;
            end
            DHIS_M8080: begin
               if (wr_fall) begin
                  nxt_act = 1'b1;
               end
               if (wr_rise && act_ff) begin
                  nxt_act = 1'b0;
                  wr_fire = 1'b1;
               end
               if (rd_fall) begin
                  rd_start = 1'b1;
                  nxt_oe   = 1'b1;
                  nxt_dout = read_word;
               end
               if (rd_rise) begin
                  nxt_oe = 1'b0;
               end
               wr_word.is_data = pin_s.dc;
               wr_word.value   = pin_s.d & width_mask;
            end
            DHIS_SPI4,
            DHIS_SPI3: begin
               // the host grounds the read strobe here; four-wire uses the
               // write strobe as its clock, the parallel branches above are
               // not taken, and the read path never fires
               if (sck_rise) begin
                  nxt_shift = shifted;
                  nxt_cnt   = 4'(cnt_ff + 4'h1);
                  if (nxt_cnt == ser_bits) begin
                     wr_fire = 1'b1;
                     nxt_cnt = 4'h0;
                  end
               end
               wr_word.value = {10'h000, shifted[7:0]};
               if (mode == DHIS_SPI4) begin
                  wr_word.is_data = pin_s.dc;
               end else begin
                  wr_word.is_data = shifted[8];
               end
            end
         endcase
      end
      // width command arms; the next command byte carries the pair
      if (wr_fire && buf_in_ready && !wr_word.is_data) begin
         if (armed_ff) begin
            nxt_upper = wr_word.value[`DHIS_WIDTH_HI:`DHIS_WIDTH_LO];
            nxt_armed = 1'b0;
         end else begin
            nxt_armed = (wr_word.value[7:0] == `DHIS_WIDTH_CMD);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_q_ff <= `DHIS_PIN_IDLE;
         upper_ff <= `DHIS_UPPER_RST;
         armed_ff <= 1'b0;
         act_ff   <= 1'b0;
         oe_ff    <= 1'b0;
         dout_ff  <= 18'h00000;
         shift_ff <= 9'h000;
         cnt_ff   <= 4'h0;
      end else begin
         pin_q_ff <= nxt_pin_q;
         upper_ff <= nxt_upper;
         armed_ff <= nxt_armed;
         act_ff   <= nxt_act;
         oe_ff    <= nxt_oe;
         dout_ff  <= nxt_dout;
         shift_ff <= nxt_shift;
         cnt_ff   <= nxt_cnt;
      end
   end

   // either source ends up as a one-cycle tick on clk, so nothing
   // downstream ever sees a second clock domain
   // clock source: internal divider or edges of the external pin
   always_comb begin
      nxt_osc  = osc_ff;
      nxt_tick = 1'b0;
      if (pin_s.osc_sel) begin
         if (osc_ff == 8'(OSC_DIV - 1)) begin
            nxt_osc  = 8'h00;
            nxt_tick = 1'b1;
         end else begin
            nxt_osc = 8'(osc_ff + 8'h01);
         end
      end else begin
         nxt_osc  = 8'h00;
         nxt_tick = pin_s.ext_clk && !pin_q_ff.ext_clk;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_ff  <= 8'h00;
         tick_ff <= 1'b0;
      end else begin
         osc_ff  <= nxt_osc;
         tick_ff <= nxt_tick;
      end
   end

   // a full buffer shows as busy; a word written while busy is lost,
   // since the host strobe cannot be held back
   dhis_buf #(
      .W ($bits(dhis_word_t))
   ) u_buf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (wr_fire),
      .in_ready  (buf_in_ready),
      .in_data   (wr_word),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (word)
   );

   assign bus_busy         = !buf_in_ready;
   assign read_req         = rd_start;
   assign read_is_data     = pin_s.dc;
   assign data_out         = dout_ff;
   assign data_oe          = oe_ff;
   assign active_mode      = mode;
   assign chip_in_reset    = !pin_s.rst_n;
   assign display_clk_tick = tick_ff;

endmodule

// ### verification/dhis_top_assertions.sv
// assertions on the pins and core side of dhis_top, bound below.
// assumes one clock domain, rst asynchronous and active high.
`timescale 1ns/1ps
module dhis_top_assertions
   import dhis_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // pins
   input wire logic [1:0]  interface_strap_bits,
   input wire logic        cs_n,
   input wire logic        data_oe,
   input wire logic [17:0] data_out,
   // core side
   input wire logic        word_valid,
   input wire logic        word_ready,
   input wire dhis_word_t  word,
   input wire logic        bus_busy,
   input wire logic        read_req,
   input wire logic [17:0] read_word,
   // status
   input wire logic [3:0]  interface_select_code,
   input wire dhis_mode_t  active_mode,
   input wire logic        chip_in_reset
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // five samples leave room for the two-flop sync and the oe register
   oe_deselect_a: assert property (cs_n [*5] |-> !data_oe)
      else $error("bus driven while deselected");
   mode_decode_a: assert property (
      active_mode == dhis_mode_t'(4'h1 << {interface_select_code[1],
         ^interface_select_code[1:0]}))
      else $error("mode does not match select code");
   strap_follow_a: assert property (
      !$past(rst) && !$past(rst, 2)
      |-> interface_select_code[1:0] == $past(interface_strap_bits, 2))
      else $error("low select bits do not follow straps");
   upper_clear_a: assert property (
      chip_in_reset |=> interface_select_code[3:2] == 2'h0)
      else $error("upper select bits kept in reset");
   read_drive_a: assert property (
      read_req |=> data_oe && data_out == $past(read_word))
      else $error("read word not driven");
   read_select_a: assert property (
      read_req |-> !$past(cs_n, 2))
      else $error("read started while deselected");
   full_valid_a: assert property (bus_busy |-> word_valid)
      else $error("buffer full without a valid word");
   stall_hold_a: assert property (
      word_valid && !word_ready |=> word_valid && $stable(word))
      else $error("stalled word lost or changed");
endmodule
bind dhis_top dhis_top_assertions chk_i (
   .clk, .rst, .interface_strap_bits, .cs_n, .data_oe, .data_out,
   .word_valid, .word_ready, .word, .bus_busy, .read_req, .read_word,
   .interface_select_code, .active_mode, .chip_in_reset
);

// ### verification/dhis_host_model.sv
// host model: 6800/8080 parallel cycles and 3/4-wire serial writes.
// assumes clk is the block's clock; half a bus period is 10 clocks.
`timescale 1ns/1ps
module dhis_host_model (
   // clock and bus return
   input  wire logic        clk,
   input  wire logic        data_oe,
   input  wire logic [17:0] data_out,
   // host pins
   output logic             cs_n,
   output logic             dc_sel,
   output logic             rw_wr_n,
   output logic             e_rd_n,
   output wire logic [17:0] data_in
);
   logic [17:0] hd;
   logic        sel;
   // released lines show an inverted pattern, never a stale copy
   assign data_in = data_oe ? data_out : hd;
   initial begin
      sel = 1'b1;
      hd = 18'h00000;
      cs_n = 1'b1;
      dc_sel = 1'b0;
      idle(2'h2);
   end
   // idle grounds both strobes in serial modes; serial clock idles low
   task automatic idle(input logic [1:0] m);
      rw_wr_n = (m == 2'h2);
      e_rd_n = (m == 2'h2);
   endtask
   task automatic step();
      repeat (10) @(posedge clk);
      #1;
   endtask
   task automatic pwr(input logic [1:0] m, input logic dc,
                      input logic [17:0] v);
      cs_n = !sel;
      dc_sel = dc;
      hd = v;
      step();
      if (m == 2'h3) e_rd_n = 1'b1;
      else rw_wr_n = 1'b0;
      step();
      idle(m);
      step();
      cs_n = 1'b1;
      hd = ~hd;
      step();
   endtask
   task automatic prd(input logic [1:0] m, input logic dc,
                      output logic [17:0] r);
      cs_n = !sel;
      dc_sel = dc;
      hd = ~hd;
      if (m == 2'h3) rw_wr_n = 1'b1;
      step();
      e_rd_n = (m == 2'h3);
      step();
      r = data_in;
      e_rd_n = (m != 2'h3);
      step();
      idle(m);
      cs_n = 1'b1;
      step();
   endtask
   task automatic spi(input logic [1:0] m, input logic dc,
                      input logic [7:0] b);
      logic [8:0] bits;
      bits = (m == 2'h1) ? {dc, b} : {b, 1'b0};
      cs_n = !sel;
      dc_sel = (m == 2'h0) & dc;
      for (int i = 0; i < 8 + m; i++) begin
         hd = (m == 2'h1) ? {16'h0000, bits[8 - i], 1'b0}
                          : {17'h00000, bits[8 - i]};
         step();
         if (m == 2'h1) hd[0] = 1'b1;
         else rw_wr_n = 1'b1;
         step();
         if (m == 2'h1) hd[0] = 1'b0;
         else rw_wr_n = 1'b0;
      end
      step();
      cs_n = 1'b1;
      step();
   endtask
endmodule

// ### verification/dhis_bench.sv
// self-checking bench for dhis_top with the host model on its pins.
// assumes OSC_DIV of 4 and a host half period of 10 clocks.
`timescale 1ns/1ps
module dhis_bench
   import dhis_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  interface_strap_bits = 2'h2;
   logic        oscillator_select = 1'b1;
   logic        external_clock_in = 1'b0;
   logic        chip_reset_n = 1'b1;
   logic        word_ready = 1'b1;
   logic [17:0] read_word = 18'h2B4C3;
   logic        cs_n, dc_sel, rw_wr_n, e_rd_n, data_oe, word_valid;
   logic        bus_busy, read_req, read_is_data, chip_in_reset;
   logic        display_clk_tick;
   logic [17:0] data_in, data_out;
   logic [3:0]  interface_select_code;
   dhis_word_t  word;
   dhis_mode_t  active_mode;
   dhis_word_t  got_q[$];
   int          errors = 0;
   int          checked = 0;
   int          cyc = 0;
   int          ticks = 0;
   logic        rd_kind = 1'b0;
   always #2 clk = ~clk;
   dhis_top #(.OSC_DIV(4)) uut (
      .clk, .rst, .interface_strap_bits, .oscillator_select,
      .external_clock_in, .chip_reset_n, .cs_n, .dc_sel, .rw_wr_n, .e_rd_n,
      .data_in, .data_out, .data_oe, .word_valid, .word_ready, .word,
      .bus_busy, .read_req, .read_is_data, .read_word,
      .interface_select_code, .active_mode, .chip_in_reset,
      .display_clk_tick
   );
   dhis_host_model host (
      .clk, .data_oe, .data_out, .cs_n, .dc_sel, .rw_wr_n, .e_rd_n, .data_in
   );
   task automatic chk(input string what, input logic [18:0] exp,
                      input logic [18:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic exp_word(input logic dc, input logic [17:0] v);
      chk("word waiting", 19'h1, 19'(got_q.size() != 0));
      if (got_q.size() != 0) chk("word", {dc, v}, got_q.pop_front());
   endtask
   task automatic set_mode(input logic [1:0] m);
      interface_strap_bits = m;
      host.idle(m);
      host.step();
   endtask
   task automatic t_parallel(input logic [1:0] m);
      // upper code 10 is undefined and is taken as 8 bits
      logic [7:0]  sb [4] = '{8'h40, 8'h00, 8'h80, 8'hC0};
      logic [17:0] mask [4] = '{18'h0FFFF, 18'h000FF, 18'h000FF,
                                18'h3FFFF};
      logic [17:0] r;
      set_mode(m);
      chk("mode", (m == 2'h3) ? 19'h4 : 19'h8, active_mode);
      for (int i = 0; i < 4; i++) begin
         host.pwr(m, 1'b0, 18'h000AB);
         host.pwr(m, 1'b0, {10'h000, sb[i]});
         host.pwr(m, 1'b1, 18'h3FFFF);
         exp_word(1'b0, 18'h000AB);
         exp_word(1'b0, {10'h000, sb[i]});
         exp_word(1'b1, mask[i]);
         chk("code", {sb[i][7:6], m}, interface_select_code);
      end
      // a command read first, then a data read
      for (int k = 0; k < 2; k++) begin
         host.prd(m, k[0], r);
         chk("read data", 19'h2B4C3, r);
         chk("read kind", 19'(k), rd_kind);
      end
      chk("read made word", 19'h0, 19'(got_q.size()));
   endtask
   task automatic t_desel();
      logic [17:0] r;
      host.sel = 1'b0;
      host.pwr(2'h3, 1'b1, 18'h00055);
      host.prd(2'h3, 1'b1, r);
      host.sel = 1'b1;
      chk("deselected words", 19'h0, 19'(got_q.size()));
      chk("deselected read", 19'h1, 19'(r !== read_word));
   endtask
   task automatic t_buffer();
      word_ready = 1'b0;
      for (int i = 0; i < 3; i++) host.pwr(2'h3, 1'b1, 18'h00010 + 18'(i));
      chk("buffer full", 19'h1, bus_busy);
      chk("held word", {1'b1, 18'h00010}, word);
      word_ready = 1'b1;
      host.step();
      exp_word(1'b1, 18'h00010);
      exp_word(1'b1, 18'h00011);
      chk("word past full", 19'h0, 19'(got_q.size()));
   endtask
   // upper select bits still hold 11 here, which serial modes ignore
   task automatic t_serial();
      set_mode(2'h0);
      chk("mode", 19'h1, active_mode);
      host.spi(2'h0, 1'b1, 8'hA5);
      exp_word(1'b1, 18'h000A5);
      set_mode(2'h1);
      chk("mode", 19'h2, active_mode);
      host.spi(2'h1, 1'b0, 8'h3C);
      exp_word(1'b0, 18'h0003C);
   endtask
   task automatic t_clock();
      ticks = 0;
      repeat (40) @(posedge clk);
      #1;
      chk("internal ticks", 19'h0000A, 19'(ticks));
      oscillator_select = 1'b0;
      host.step();
      ticks = 0;
      // board clock at 80 ns, off the phase of clk
      repeat (5) begin
         #37.3 external_clock_in = 1'b1;
         #40 external_clock_in = 1'b0;
         #2.7;
      end
      host.step();
      chk("external ticks", 19'h00005, 19'(ticks));
      oscillator_select = 1'b1;
   endtask
   task automatic t_chip_reset();
      chip_reset_n = 1'b0;
      host.step();
      chk("in reset", 19'h1, chip_in_reset);
      chk("code", 19'h1, interface_select_code);
      chip_reset_n = 1'b1;
      host.step();
      chk("in reset", 19'h0, chip_in_reset);
   endtask
   task automatic tally_and_finish();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      if (word_valid === 1'b1 && word_ready === 1'b1) got_q.push_back(word);
      if (display_clk_tick === 1'b1) ticks++;
      if (read_req === 1'b1) rd_kind = read_is_data;
      cyc++;
      if (cyc == 8000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      host.step();
      chk("code", 19'h2, interface_select_code);
      t_parallel(2'h2);
      t_parallel(2'h3);
      t_desel();
      t_buffer();
      t_serial();
      t_clock();
      t_chip_reset();
      tally_and_finish();
   end
endmodule
